// File: xdfr_pkg.sv
/*
 * Shared constants, states and carrier types of the X-capacitor discharge
 * and fault-latch fast-reset sequencer.
 * Assumes a 200 MHz core clock; an analog front end turns the current
 * codes and figures into real currents.
 */
package xdfr_pkg;

    localparam int unsigned XDFR_CLK_HZ     = 200_000_000;
    localparam int unsigned XDFR_CYC_PER_US = XDFR_CLK_HZ / 1_000_000;
    localparam int          XDFR_CNT_W      = 28;
    localparam int          XDFR_UA_W       = 12;

    // Times in microseconds.
    localparam int unsigned XDFR_LEVEL_US     = 12_000;
    localparam int unsigned XDFR_DWELL_US     = 48_000;
    localparam int unsigned XDFR_DETECT_US    = 84_000;
    localparam int unsigned XDFR_DISCHARGE_US = 300_000;
    localparam int unsigned XDFR_BLANK_US     = 700_000;
    localparam int unsigned XDFR_WAIT_US      = 700_000;

    // Derived cycle counts; every figure divides exactly at 200 MHz.
    localparam logic [XDFR_CNT_W-1:0] XDFR_LEVEL_CYC =
        XDFR_CNT_W'(XDFR_LEVEL_US * XDFR_CYC_PER_US);
    localparam logic [XDFR_CNT_W-1:0] XDFR_DWELL_CYC =
        XDFR_CNT_W'(XDFR_DWELL_US * XDFR_CYC_PER_US);
    localparam logic [XDFR_CNT_W-1:0] XDFR_DISCHARGE_CYC =
        XDFR_CNT_W'(XDFR_DISCHARGE_US * XDFR_CYC_PER_US);
    localparam logic [XDFR_CNT_W-1:0] XDFR_BLANK_CYC =
        XDFR_CNT_W'(XDFR_BLANK_US * XDFR_CYC_PER_US);
    localparam logic [XDFR_CNT_W-1:0] XDFR_WAIT_CYC =
        XDFR_CNT_W'(XDFR_WAIT_US * XDFR_CYC_PER_US);

    // Analog thresholds and currents (millivolts, microamps).
    localparam int unsigned XDFR_CROSS_MV     = 6_500;
    localparam int unsigned XDFR_SHORT_MV     = 4_000;
    localparam int unsigned XDFR_LOGIC_RST_MV = 4_300;
    localparam logic [XDFR_UA_W-1:0] XDFR_DISCH_UA  = 12'h7d0;
    localparam logic [XDFR_UA_W-1:0] XDFR_LEVEL2_UA = 12'h307;
    localparam logic [XDFR_UA_W-1:0] XDFR_PROBE_UA  = 12'h050;

    localparam logic [1:0] XDFR_LEVEL_LAST = 2'h3;

    typedef enum logic [2:0] {
        XDFR_ST_IDLE,
        XDFR_ST_PROBE,
        XDFR_ST_OFF,
        XDFR_ST_DETECT,
        XDFR_ST_DISCHARGE,
        XDFR_ST_BLANK,
        XDFR_ST_WAIT
    } xdfr_state_t;

    // Asynchronous inputs from the pins and the supply monitor.
    typedef struct packed {
        logic line_cmp_a;   // Sense pin A above the zero-cross level.
        logic line_cmp_b;   // Sense pin B above the zero-cross level.
        logic short_low;    // Sense pins below the short-detect level.
        logic supply_on;    // Supply has reached its turn-on level.
        logic run;          // Run signal from the controller.
    } xdfr_pins_t;

    // Commands to the analog current sources on the sense pins.
    typedef struct packed {
        logic       probe_en;       // Source probe current out of pins.
        logic       test_en;        // Sink staircase test current.
        logic [1:0] test_level;     // Staircase step, 0 is lowest.
        logic       discharge_en;   // Sink discharge current.
    } xdfr_drive_t;

endpackage

// File: xdfr_sync.sv
/*
 * Two-flop synchroniser for a bundle of unrelated level inputs.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps
module xdfr_sync
    import xdfr_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         core_clk,   // Core clock.
    input  wire logic         rst,        // Asynchronous reset, high.
    input  wire logic [W-1:0] async_in,   // Inputs from another domain.
    output logic      [W-1:0] sync_out    // Synchronised levels.
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end

endmodule

// File: xdfr_timer.sv
/*
 * Reloadable down-counter that raises a one-cycle pulse when it runs out.
 * Assumes the caller reloads it on every phase entry; a start beats expiry.
 */
`timescale 1ns/100ps
module xdfr_timer
    import xdfr_pkg::*;
#(
    parameter int W = XDFR_CNT_W
)
(
    input  wire logic         core_clk,    // Core clock.
    input  wire logic         rst,         // Asynchronous reset, high.
    input  wire logic         start,       // Load and arm, one cycle.
    input  wire logic [W-1:0] start_val,   // Cycles until expiry.
    output logic              expired_ff   // Pulse when count runs out.
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         nxt_expired;

    always_comb
    begin
        nxt_cnt     = cnt_ff;
        nxt_expired = 1'b0;
        if (start)
        begin
            nxt_cnt = start_val;
        end
        else if (cnt_ff != '0)
        begin
            nxt_cnt     = cnt_ff - W'(1);
            nxt_expired = (cnt_ff == W'(1));
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff     <= '0;
            expired_ff <= 1'b0;
        end
        else
        begin
            cnt_ff     <= nxt_cnt;
            expired_ff <= nxt_expired;
        end
    end

endmodule

// File: xdfr_top.sv
/*
 * Sequencer for active X-capacitor discharge and fault-latch fast reset.
 * It checks the pins for a short, steps a test current, discharges on line
 * loss and clears the fault latch when the line returns.
 * Assumes rst is the supply logic-reset monitor, pins_in comes straight
 * from analog comparators, and fault_set/single_wire are on core_clk.
 */
`timescale 1ns/100ps
module xdfr_top
    import xdfr_pkg::*;
#(
    parameter logic [XDFR_CNT_W-1:0] LEVEL_CYC     = XDFR_LEVEL_CYC,
    parameter logic [XDFR_CNT_W-1:0] DWELL_CYC     = XDFR_DWELL_CYC,
    parameter logic [XDFR_CNT_W-1:0] DISCHARGE_CYC = XDFR_DISCHARGE_CYC,
    parameter logic [XDFR_CNT_W-1:0] BLANK_CYC     = XDFR_BLANK_CYC,
    parameter logic [XDFR_CNT_W-1:0] WAIT_CYC      = XDFR_WAIT_CYC,
    parameter logic [XDFR_UA_W-1:0]  LEVEL1_UA     = 12'h0fa,
    parameter logic [XDFR_UA_W-1:0]  LEVEL3_UA     = 12'h4e2,
    parameter logic [XDFR_UA_W-1:0]  LEVEL4_UA     = 12'h7d0
)
(
    input  wire logic                 core_clk,          // Core clock.
    input  wire logic                 rst,               // Supply reset, high.
    input  xdfr_pins_t                pins_in,           // Async pin levels.
    input  wire logic                 fault_set,         // Protection trip.
    input  wire logic                 single_wire,       // One-conductor sense.
    output xdfr_drive_t               drive_ff,          // Pin current control.
    output logic      [XDFR_UA_W-1:0] current_ua_ff,     // Current magnitude.
    output logic                      line_loss_latch_ff, // Line removed.
    output logic                      fault_latch_ff,    // Protection latched.
    output logic                      switching_en_ff,   // Converter may run.
    output logic                      restart_cycle_ff,  // Cycle the supply.
    output logic                      functions_off_ff,  // Pins found shorted.
    output logic                      zero_cross_ff      // Crossing seen.
);

    xdfr_pins_t pins_s;
    logic        lz_prev_ff;
    logic        run_prev_ff;
    xdfr_state_t state_ff;
    logic [1:0]  level_ff;
    logic        half_ff;
    logic        tmr_expired;

    xdfr_state_t           nxt_state;
    logic [1:0]            nxt_level;
    logic                  nxt_half;
    logic                  nxt_lz_prev;
    logic                  nxt_run_prev;
    logic                  tmr_start;
    logic [XDFR_CNT_W-1:0] tmr_val;
    xdfr_drive_t           nxt_drive;
    logic [XDFR_UA_W-1:0]  nxt_current;
    logic                  nxt_line_loss;
    logic                  nxt_fault;
    logic                  nxt_switching;
    logic                  nxt_restart;
    logic                  nxt_off;
    logic                  nxt_zc;

    logic line_level;
    logic zc;
    logic run_rise;
    logic sensing;

    // Comparator and supply levels cross from the analog world here.
    xdfr_sync #(
        .W        ($bits(xdfr_pins_t))
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (pins_in),
        .sync_out (pins_s)
    );

    xdfr_timer #(
        .W          (XDFR_CNT_W)
    ) u_timer (
        .core_clk   (core_clk),
        .rst        (rst),
        .start      (tmr_start),
        .start_val  (tmr_val),
        .expired_ff (tmr_expired)
    );

    // Staircase step to test-current magnitude.
    function automatic logic [XDFR_UA_W-1:0] level_ua(input logic [1:0] lvl);
        logic [XDFR_UA_W-1:0] ua;
        unique case (lvl)
            2'h0: ua = LEVEL1_UA;
            2'h1: ua = XDFR_LEVEL2_UA;
            2'h2: ua = LEVEL3_UA;
            2'h3: ua = LEVEL4_UA;
        endcase
        return ua;
    endfunction

    // Timer reload for a staircase step: the top step dwells longer.
    function automatic logic [XDFR_CNT_W-1:0] level_cyc(input logic [1:0] lvl);
        return (lvl == XDFR_LEVEL_LAST) ? DWELL_CYC : LEVEL_CYC;
    endfunction

    // Either pin may carry the crossing, so one open pin is tolerated.
    assign line_level = pins_s.line_cmp_a | pins_s.line_cmp_b;
    // Crossings only mean something while a sink current is applied.
    assign sensing    = (state_ff == XDFR_ST_DETECT) ||
                        (state_ff == XDFR_ST_DISCHARGE);
    assign zc         = sensing && line_level && !lz_prev_ff;
    assign run_rise   = pins_s.run && !run_prev_ff;

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_level    = level_ff;
        nxt_half     = half_ff;
        nxt_lz_prev  = line_level;
        nxt_run_prev = pins_s.run;
        tmr_start    = 1'b0;
        tmr_val      = LEVEL_CYC;
        nxt_off      = functions_off_ff;
        nxt_line_loss = line_loss_latch_ff;

        // Not gated by the fault latch, so the line is watched in hiccups.
        unique case (state_ff)
            XDFR_ST_IDLE:
            begin
                if (pins_s.supply_on)
                begin
                    nxt_state = XDFR_ST_PROBE;
                end
            end
            XDFR_ST_PROBE:
            begin
                if (run_rise)
                begin
                    if (pins_s.short_low)
                    begin
                        nxt_state = XDFR_ST_OFF;
                        nxt_off   = 1'b1;
                    end
                    else
                    begin
                        nxt_state = XDFR_ST_DETECT;
                        nxt_level = 2'h0;
                        nxt_half  = 1'b0;
                        tmr_start = 1'b1;
                        tmr_val   = level_cyc(2'h0);
                    end
                end
            end
            XDFR_ST_OFF:
            begin
                // Left only through the supply logic reset.
                nxt_state = XDFR_ST_OFF;
            end
            XDFR_ST_DETECT:
            begin
                if (zc)
                begin
                    nxt_state = XDFR_ST_WAIT;
                    tmr_start = 1'b1;
                    tmr_val   = WAIT_CYC;
                end
                else if (tmr_expired)
                begin
                    if (level_ff == XDFR_LEVEL_LAST)
                    begin
                        // Line removal confirmed after the whole window.
                        nxt_state     = XDFR_ST_DISCHARGE;
                        nxt_line_loss = 1'b1;
                        tmr_start     = 1'b1;
                        tmr_val       = DISCHARGE_CYC;
                    end
                    else if (single_wire && !half_ff)
                    begin
                        // Slow line signal: allow a second period.
                        nxt_half  = 1'b1;
                        tmr_start = 1'b1;
                        tmr_val   = LEVEL_CYC;
                    end
                    else
                    begin
                        nxt_level = level_ff + 2'h1;
                        nxt_half  = 1'b0;
                        tmr_start = 1'b1;
                        tmr_val   = level_cyc(level_ff + 2'h1);
                    end
                end
            end
            XDFR_ST_DISCHARGE:
            begin
                if (zc)
                begin
                    // Line is back, so discharging would only waste power.
                    nxt_state     = XDFR_ST_WAIT;
                    tmr_start     = 1'b1;
                    tmr_val       = WAIT_CYC;
                end
                else if (tmr_expired)
                begin
                    nxt_state = XDFR_ST_BLANK;
                    tmr_start = 1'b1;
                    tmr_val   = BLANK_CYC;
                end
            end
            XDFR_ST_BLANK,
            XDFR_ST_WAIT:
            begin
                if (tmr_expired)
                begin
                    nxt_state = XDFR_ST_DETECT;
                    nxt_level = 2'h0;
                    nxt_half  = 1'b0;
                    tmr_start = 1'b1;
                    tmr_val   = level_cyc(2'h0);
                end
            end
        endcase

        // A crossing in any sensing phase after line loss means recovery.
        if (zc && line_loss_latch_ff)
        begin
            nxt_line_loss = 1'b0;
        end
    end

    // Outputs follow the next state so they line up with state_ff.
    always_comb
    begin
        nxt_drive    = '0;
        nxt_current  = '0;
        nxt_zc       = zc;
        nxt_fault    = fault_latch_ff;
        unique case (nxt_state)
            XDFR_ST_PROBE:
            begin
                nxt_drive.probe_en = 1'b1;
                nxt_current        = XDFR_PROBE_UA;
            end
            XDFR_ST_DETECT:
            begin
                nxt_drive.test_en    = 1'b1;
                nxt_drive.test_level = nxt_level;
                nxt_current          = level_ua(nxt_level);
            end
            XDFR_ST_DISCHARGE:
            begin
                // Never sink the large current unless loss is latched.
                nxt_drive.discharge_en = nxt_line_loss;
                nxt_current = nxt_line_loss ? XDFR_DISCH_UA : '0;
            end
            default:
            begin
            end
        endcase

        // Fast reset: skips waiting for the supply to collapse. In the
        // disabled state no crossing is ever seen, so only rst clears it.
        if (zc && line_loss_latch_ff)
        begin
            nxt_fault = 1'b0;
        end
        // A trip in the same cycle as a fast reset still latches.
        if (fault_set)
        begin
            nxt_fault = 1'b1;
        end
        nxt_switching = !nxt_fault;
        nxt_restart   = nxt_fault;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff           <= XDFR_ST_IDLE;
            level_ff           <= 2'h0;
            half_ff            <= 1'b0;
            lz_prev_ff         <= 1'b0;
            run_prev_ff        <= 1'b0;
            functions_off_ff   <= 1'b0;
            line_loss_latch_ff <= 1'b0;
        end
        else
        begin
            state_ff           <= nxt_state;
            level_ff           <= nxt_level;
            half_ff            <= nxt_half;
            lz_prev_ff         <= nxt_lz_prev;
            run_prev_ff        <= nxt_run_prev;
            functions_off_ff   <= nxt_off;
            line_loss_latch_ff <= nxt_line_loss;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            drive_ff         <= '0;
            current_ua_ff    <= '0;
            fault_latch_ff   <= 1'b0;
            switching_en_ff  <= 1'b1;
            restart_cycle_ff <= 1'b0;
            zero_cross_ff    <= 1'b0;
        end
        else
        begin
            drive_ff         <= nxt_drive;
            current_ua_ff    <= nxt_current;
            fault_latch_ff   <= nxt_fault;
            switching_en_ff  <= nxt_switching;
            restart_cycle_ff <= nxt_restart;
            zero_cross_ff    <= nxt_zc;
        end
    end

endmodule

// File: xdfr_top_assertions.sv
/* Port-level checks for the discharge and fast-reset sequencer.
   Assumes binding into xdfr_top with the same timer parameters. */
`timescale 1ns/100ps
module xdfr_top_assertions
    import xdfr_pkg::*;
#(
    parameter logic [XDFR_CNT_W-1:0] LEVEL_CYC     = XDFR_LEVEL_CYC,
    parameter logic [XDFR_CNT_W-1:0] DWELL_CYC     = XDFR_DWELL_CYC,
    parameter logic [XDFR_CNT_W-1:0] DISCHARGE_CYC = XDFR_DISCHARGE_CYC
)
(
    input wire logic                 core_clk,           // Core clock.
    input wire logic                 rst,                // Supply reset.
    input xdfr_pins_t                pins_in,            // Pin levels.
    input wire logic                 fault_set,          // Trip.
    input wire logic                 single_wire,        // One conductor.
    input xdfr_drive_t               drive_ff,           // Pin currents.
    input wire logic [XDFR_UA_W-1:0] current_ua_ff,      // Magnitude.
    input wire logic                 line_loss_latch_ff, // Line removed.
    input wire logic                 fault_latch_ff,     // Fault held.
    input wire logic                 switching_en_ff,    // Converter on.
    input wire logic                 restart_cycle_ff,   // Supply cycling.
    input wire logic                 functions_off_ff,   // Pins shorted.
    input wire logic                 zero_cross_ff       // Crossing.
);
    xdfr_drive_t           prev_ff;
    logic [XDFR_CNT_W-1:0] run_ff;
    // Length of the last drive phase, too long to unroll as a delay.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prev_ff <= '0;
            run_ff  <= '0;
        end
        else
        begin
            prev_ff <= drive_ff;
            run_ff  <= (drive_ff != prev_ff) ? 28'h1 : run_ff + 28'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_step;
        drive_ff.test_en && prev_ff.test_en &&
        drive_ff.test_level != prev_ff.test_level;
    endsequence
    sequence s_to_disch;
        drive_ff.discharge_en && prev_ff.test_en;
    endsequence
    sequence s_disch_end;
        prev_ff.discharge_en && !drive_ff.discharge_en && !zero_cross_ff;
    endsequence
    chk_disch_gated: assert property (
        drive_ff.discharge_en |->
        line_loss_latch_ff && current_ua_ff == XDFR_DISCH_UA)
        else $error("discharge without loss or wrong current");
    chk_fault_set: assert property (
        fault_set |=> fault_latch_ff)
        else $error("fault latch not set");
    chk_fault_out: assert property (
        switching_en_ff == !fault_latch_ff &&
        restart_cycle_ff == fault_latch_ff)
        else $error("switching or restart disagree with fault");
    chk_level_step: assert property (
        s_step |-> drive_ff.test_level == prev_ff.test_level + 2'h1 &&
        (single_wire || run_ff == LEVEL_CYC + 28'h1))
        else $error("bad staircase step");
    chk_dwell_end: assert property (
        s_to_disch |-> prev_ff.test_level == XDFR_LEVEL_LAST &&
        run_ff == DWELL_CYC + 28'h1 && line_loss_latch_ff)
        else $error("bad dwell before discharge");
    chk_disch_len: assert property (
        s_disch_end |-> run_ff == DISCHARGE_CYC + 28'h1 && drive_ff == '0)
        else $error("bad discharge length");
    chk_cross_quiet: assert property (
        zero_cross_ff |-> drive_ff == '0 && current_ua_ff == '0)
        else $error("current after crossing");
    chk_fast_clear: assert property (
        zero_cross_ff && $past(line_loss_latch_ff) && !$past(fault_set)
        |-> !fault_latch_ff && !line_loss_latch_ff)
        else $error("latches not cleared by crossing");
    chk_off_quiet: assert property (
        functions_off_ff |-> drive_ff == '0 && current_ua_ff == '0)
        else $error("current while disabled");
    chk_off_sticky: assert property (
        functions_off_ff |=> functions_off_ff)
        else $error("disable lost");
    chk_lvl2_cur: assert property (
        drive_ff.test_en && drive_ff.test_level == 2'h1 |->
        current_ua_ff == XDFR_LEVEL2_UA)
        else $error("second level current wrong");
    chk_probe_cur: assert property (
        drive_ff.probe_en |-> current_ua_ff == XDFR_PROBE_UA)
        else $error("probe current wrong");
endmodule
bind xdfr_top xdfr_top_assertions #(.LEVEL_CYC(LEVEL_CYC),
    .DWELL_CYC(DWELL_CYC), .DISCHARGE_CYC(DISCHARGE_CYC)) u_chk (
    .core_clk(core_clk), .rst(rst), .pins_in(pins_in),
    .fault_set(fault_set), .single_wire(single_wire), .drive_ff(drive_ff),
    .current_ua_ff(current_ua_ff), .line_loss_latch_ff(line_loss_latch_ff),
    .fault_latch_ff(fault_latch_ff), .switching_en_ff(switching_en_ff),
    .restart_cycle_ff(restart_cycle_ff),
    .functions_off_ff(functions_off_ff), .zero_cross_ff(zero_cross_ff));

// File: xdfr_mains.sv
/* Mains sensing network on the two redundant sense pins.
   Assumes core_clk paces it; an open pin reads low. */
`timescale 1ns/100ps
module xdfr_mains
#(
    parameter int HALF = 5
)
(
    input  wire logic core_clk,   // Core clock.
    input  wire logic line_on,    // Mains connected.
    input  wire logic open_a,     // Pin A open.
    input  wire logic open_b,     // Pin B open.
    output logic      line_cmp_a, // Pin A above threshold.
    output logic      line_cmp_b  // Pin B above threshold.
);
    int   cnt  = 0;
    logic wave = 1'b0;
    always_ff @(posedge core_clk)
    begin
        cnt  <= (cnt == HALF - 1) ? 0 : cnt + 1;
        wave <= (cnt == HALF - 1) ? ~wave : wave;
    end
    assign line_cmp_a = line_on && !open_a && wave;
    assign line_cmp_b = line_on && !open_b && wave;
endmodule

// File: xdfr_top_tb.sv
/* Self-checking bench for the discharge and fast-reset sequencer.
   Assumes the mains model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module xdfr_top_tb;
    import xdfr_pkg::*;
    localparam logic [27:0] LV = 28'h14, DW = 28'h50, DC = 28'h32;
    localparam logic [27:0] BK = 28'h64, WT = 28'h64;
    localparam logic [11:0] U1 = 12'h0fa, U3 = 12'h4e2, U4 = 12'h7d0;
    logic        core_clk = 1'b0, rst = 1'b1, fault_set = 1'b0;
    logic        single_wire = 1'b0, line_on = 1'b0;
    logic        open_a = 1'b0, open_b = 1'b0, short_low = 1'b0;
    logic        supply_on = 1'b0, run = 1'b0, cmp_a, cmp_b;
    logic        loss, flt, sw_en, restart, off, zc;
    logic [11:0] cur;
    logic [11:0] ua [4] = '{U1, XDFR_LEVEL2_UA, U3, U4};
    xdfr_drive_t drive;
    int          error_cnt = 0, n_compared = 0, seed = 43629;
    logic [16:0] exp_q [$];
    int          len_q [$];
    always #2.5 core_clk = ~core_clk;
    xdfr_mains u_mains (.core_clk(core_clk), .line_on(line_on),
        .open_a(open_a), .open_b(open_b), .line_cmp_a(cmp_a),
        .line_cmp_b(cmp_b));
    xdfr_top #(.LEVEL_CYC(LV), .DWELL_CYC(DW), .DISCHARGE_CYC(DC),
        .BLANK_CYC(BK), .WAIT_CYC(WT), .LEVEL1_UA(U1), .LEVEL3_UA(U3),
        .LEVEL4_UA(U4)) dut (.core_clk(core_clk), .rst(rst),
        .pins_in({cmp_a, cmp_b, short_low, supply_on, run}),
        .fault_set(fault_set), .single_wire(single_wire), .drive_ff(drive),
        .current_ua_ff(cur), .line_loss_latch_ff(loss),
        .fault_latch_ff(flt), .switching_en_ff(sw_en),
        .restart_cycle_ff(restart), .functions_off_ff(off),
        .zero_cross_ff(zc));
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [27:0] e,
                       input logic [27:0] s);
        n_compared++;
        if (e !== s)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic span(input logic [16:0] e, output int c);
        for (c = 0; c < 3000 && {drive, cur} !== e; c++) tick(1);
        for (c = 0; c < 3000 && {drive, cur} === e; c++) tick(1);
    endtask
    task automatic phase(input logic [16:0] e, input int n);
        int c;
        span(e, c);
        chk("phase", n, c);
    endtask
    task automatic wait_zc;
        int c;
        for (c = 0; c < 500 && zc !== 1'b1; c++) tick(1);
        chk("zc", 1, zc);
    endtask
    // Expected phases are queued from the timing rules, then replayed.
    task automatic stair;
        for (int l = 0; l < 4; l++)
        begin
            exp_q.push_back({2'b01, 2'(l), 1'b0, ua[l]});
            len_q.push_back((l == 3 ? DW : LV) + 1);
        end
        exp_q.push_back({5'h01, XDFR_DISCH_UA});
        len_q.push_back(DC + 1);
        exp_q.push_back(17'h0);
        len_q.push_back(BK + 1);
        while (exp_q.size() > 0)
            phase(exp_q.pop_front(), len_q.pop_front());
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        finish_test();
    end
    initial
    begin
        int c;
        tick(6);
        rst = 1'b0;
        chk("sw_en", 1, sw_en);
        chk("idle", 0, {drive, cur});
        supply_on = 1'b1;
        tick(4);
        chk("probe", {5'h10, XDFR_PROBE_UA}, {drive, cur});
        run = 1'b1;
        stair();
        chk("loss", 1, loss);
        $display("test staircase done");
        fault_set = 1'b1;
        tick(1);
        fault_set = 1'b0;
        chk("fault", 1, flt);
        chk("sw_en", 0, sw_en);
        chk("restart", 1, restart);
        open_a = 1'b1;
        line_on = 1'b1;
        wait_zc();
        chk("fault", 0, flt);
        chk("loss", 0, loss);
        line_on = 1'b0;
        open_a = 1'b0;
        phase(17'h0, WT + 1);
        $display("test fast reset done");
        phase({2'b01, 2'h0, 1'b0, U1}, LV + 1);
        tick($unsigned($random(seed)) % 8);
        line_on = 1'b1;
        wait_zc();
        chk("abort", 0, {drive, cur});
        line_on = 1'b0;
        single_wire = 1'b1;
        phase(17'h0, WT + 1);
        span({2'b01, 2'h0, 1'b0, U1}, c);
        chk("span", 2 * LV + 2, c);
        $display("test abort and single wire done");
        rst = 1'b1;
        run = 1'b0;
        short_low = 1'b1;
        single_wire = 1'b0;
        tick(2);
        rst = 1'b0;
        tick(6);
        chk("probe", {5'h10, XDFR_PROBE_UA}, {drive, cur});
        run = 1'b1;
        tick(5);
        chk("off", 1, off);
        chk("quiet", 0, {drive, cur});
        fault_set = 1'b1;
        tick(1);
        fault_set = 1'b0;
        line_on = 1'b1;
        tick(200);
        chk("fault", 1, flt);
        rst = 1'b1;
        tick(1);
        chk("fault", 0, flt);
        $display("test short done");
        finish_test();
    end
endmodule
